/* common/bzg_pkg.sv */
// constants, register map and carrier types of the buzzer tone generator
// assumes a 100 MHz system clock and an 8-bit register port
package bzg_pkg;
  localparam int SYS_HZ  = 100_000_000;
  // tone base rate, twice the 32.768 kHz low-speed clock
  localparam int LS_HZ   = 32_768;
  localparam int BASE_HZ = 2 * LS_HZ;
  localparam int SLOW_HZ = 256;
  localparam int SLOW_DIV = BASE_HZ / SLOW_HZ;

  // times as printed, in microseconds
  localparam int STEP_LONG_US   = 125_000;
  localparam int STEP_SHORT_US  = 62_500;
  localparam int BURST_LONG_US  = 125_000;
  localparam int BURST_SHORT_US = 31_250;
  localparam logic [5:0] STEP_LONG_T   = 6'(STEP_LONG_US * SLOW_HZ / 1_000_000);
  localparam logic [5:0] STEP_SHORT_T  = 6'(STEP_SHORT_US * SLOW_HZ / 1_000_000);
  localparam logic [5:0] BURST_LONG_T  = 6'(BURST_LONG_US * SLOW_HZ / 1_000_000);
  localparam logic [5:0] BURST_SHORT_T = 6'(BURST_SHORT_US * SLOW_HZ / 1_000_000);

  localparam logic [15:0] CTL_ADDR = 16'hff44;
  localparam logic [15:0] SEL_ADDR = 16'hff45;
  localparam int B_TON  = 0;
  localparam int B_ENV  = 1;
  localparam int B_RST  = 2;
  localparam int B_STEP = 3;
  localparam int B_LEN  = 4;
  localparam int B_TRIG = 5;
  localparam int B_KILL = 6;
  localparam int B_PITCH = 0;
  localparam int B_LEVEL = 4;
  localparam logic [2:0] PITCH_RST = 3'h0;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [2:0] LEVEL_MIN = 3'h7;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bzg_bus_t;

  typedef enum logic [1:0] {
    BST_IDLE  = 2'b00,
    BST_ARMED = 2'b01,
    BST_RUN   = 2'b11
  } bzg_bst_t;
endpackage

/* logic/bzg_base_tick.sv */
// fractional divider: one-cycle pulse at BASE_HZ on average
// assumes BASE_HZ below SYS_HZ
`timescale 1ns/1ns
`default_nettype none
module bzg_base_tick #(
  parameter int BASE_HZ = bzg_pkg::BASE_HZ
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  output logic      tick
);
  import bzg_pkg::*;

  typedef struct packed {
    logic [31:0] acc;
    logic        tick;
  } bzg_bt_st_t;

  bzg_bt_st_t st_reg;
  bzg_bt_st_t st_next;

  // accumulator keeps the long-run rate exact with no integer ratio
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.acc + 32'(BASE_HZ) >= 32'(SYS_HZ))
    begin
      st_next.acc = st_reg.acc + 32'(BASE_HZ) - 32'(SYS_HZ);
      st_next.tick = 1'b1;
    end
    else
      st_next.acc = st_reg.acc + 32'(BASE_HZ);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;
endmodule
`default_nettype wire

/* logic/bzg_buzzer.sv */
// buzzer tone generator with digital envelope and one-shot burst
// assumes a plain register port, reads answered one cycle later
// How it works
// - envelope enable steps duty, else level select
// - tone on starts level 1, steps to 8
// - restart write returns envelope to level 1
// - level 8 held until tone off/restart
// - stage time 125 or 62.5 msec
// - step select 1 long, 0 short
// - burst length 125 or 31.25 msec
// - length select 1 long, 0 short
// - trigger starts tone on 256 Hz tick
// - burst ends itself on 256 Hz tick
// - trigger bit reads busy status
// - kill stops burst immediately
// - trigger clears envelope enable
// - burst shaped by pitch and level only
// - trigger and kill ignored while tone on
// - retrigger restarts the burst timer
// - kill wins over simultaneous trigger
// - tone enable or running burst drives tone, else low
// - reset clears tone enable, pin low
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module bzg_buzzer #(
  parameter int BASE_HZ = bzg_pkg::BASE_HZ
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire bzg_pkg::bzg_bus_t bus,
  output logic [7:0]            rdata,
  output logic                  tone_pin
);
  import bzg_pkg::*;

  typedef struct packed {
    logic       ton;
    logic       env_en;
    logic       step_sel;
    logic       len_sel;
    logic [2:0] pitch;
    logic [2:0] level;
    logic [2:0] env_lvl;
    logic [5:0] stage_cnt;
    bzg_bst_t   bst;
    logic [5:0] burst_cnt;
    logic [7:0] slow_cnt;
    logic [7:0] rdata;
    logic       pin;
  } bzg_st_t;

  bzg_st_t    st_reg;
  bzg_st_t    st_next;
  logic       base_tick;
  logic       slow_tick;
  logic       wave;
  logic [2:0] duty_lvl;
  logic       wr_ctl;
  logic       wr_sel;
  logic       trig_acc;
  logic       kill_acc;
  logic       rst_acc;
  logic [5:0] stage_len;
  logic [5:0] burst_len;

  function automatic logic hit(input bzg_bus_t b, input logic [15:0] a);
    return b.addr == a;
  endfunction

  bzg_base_tick #(
    .BASE_HZ (BASE_HZ)
  ) u_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .tick    (base_tick)
  );

  bzg_tone u_tone (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .tick    (base_tick),
    .pitch   (st_reg.pitch),
    .level   (duty_lvl),
    .wave    (wave)
  );

  assign slow_tick = base_tick && (st_reg.slow_cnt == 8'(SLOW_DIV - 1));

  assign duty_lvl = (st_reg.env_en && st_reg.ton) ? st_reg.env_lvl : st_reg.level;

  assign wr_ctl = bus.wr && hit(bus, CTL_ADDR);
  assign wr_sel = bus.wr && hit(bus, SEL_ADDR);

  assign trig_acc = wr_ctl && bus.wdata[B_TRIG] && !st_reg.ton;
  assign kill_acc = wr_ctl && bus.wdata[B_KILL] && !st_reg.ton;
  assign rst_acc = wr_ctl && bus.wdata[B_RST] && st_reg.env_en;

  assign stage_len = st_reg.step_sel ? STEP_LONG_T : STEP_SHORT_T;
  assign burst_len = st_reg.len_sel ? BURST_LONG_T : BURST_SHORT_T;

  always_comb
  begin
    st_next = st_reg;
    if (base_tick)
      st_next.slow_cnt = st_reg.slow_cnt + 8'h01;

    if (wr_ctl)
    begin
      st_next.ton = bus.wdata[B_TON];
      st_next.env_en = bus.wdata[B_ENV];
      st_next.step_sel = bus.wdata[B_STEP];
      st_next.len_sel = bus.wdata[B_LEN];
    end
    if (wr_sel)
    begin
      st_next.pitch = bus.wdata[B_PITCH +: 3];
      st_next.level = bus.wdata[B_LEVEL +: 3];
    end

    // envelope runs only with the tone on; tone off parks it at level 1
    if (!st_reg.ton || !st_reg.env_en)
    begin
      st_next.env_lvl = 3'h0;
      st_next.stage_cnt = 6'h00;
    end
    else if (rst_acc)
    begin
      st_next.env_lvl = 3'h0;
      st_next.stage_cnt = 6'h00;
    end
    else if (slow_tick)
    begin
      if (st_reg.stage_cnt >= stage_len - 6'h01)
      begin
        st_next.stage_cnt = 6'h00;
        if (st_reg.env_lvl != LEVEL_MIN)
          st_next.env_lvl = st_reg.env_lvl + 3'h1;
      end
      else
        st_next.stage_cnt = st_reg.stage_cnt + 6'h01;
    end

    unique case (st_reg.bst)
      BST_IDLE:
      begin
        st_next.burst_cnt = 6'h00;
      end
      BST_ARMED:
      begin
        if (slow_tick)
        begin
          st_next.bst = BST_RUN;
          st_next.burst_cnt = 6'h00;
        end
      end
      BST_RUN:
      begin
        if (slow_tick)
        begin
          if (st_reg.burst_cnt >= burst_len - 6'h01)
            st_next.bst = BST_IDLE;
          else
            st_next.burst_cnt = st_reg.burst_cnt + 6'h01;
        end
      end
      default:
      begin
        st_next.bst = BST_IDLE;
      end
    endcase

    if (trig_acc)
    begin
      st_next.env_en = 1'b0;
      if (st_reg.bst == BST_IDLE)
        st_next.bst = BST_ARMED;
      else if (st_reg.bst == BST_RUN)
      begin
        st_next.burst_cnt = 6'h00;
        st_next.bst = BST_RUN;
      end
    end
    if (kill_acc)
      st_next.bst = BST_IDLE;

    st_next.pin = (st_reg.ton || st_reg.bst == BST_RUN) && wave;

    st_next.rdata = 8'h00;
    if (bus.rd && hit(bus, CTL_ADDR))
    begin
      st_next.rdata[B_TON] = st_reg.ton;
      st_next.rdata[B_ENV] = st_reg.env_en;
      st_next.rdata[B_STEP] = st_reg.step_sel;
      st_next.rdata[B_LEN] = st_reg.len_sel;
      st_next.rdata[B_TRIG] = st_reg.bst != BST_IDLE;
      st_next.rdata[B_RST] = 1'b0;
      st_next.rdata[B_KILL] = 1'b0;
    end
    else if (bus.rd && hit(bus, SEL_ADDR))
    begin
      st_next.rdata[B_PITCH +: 3] = st_reg.pitch;
      st_next.rdata[B_LEVEL +: 3] = st_reg.level;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.pitch <= PITCH_RST;
      st_reg.level <= LEVEL_RST;
      st_reg.bst <= BST_IDLE;
    end
    else if (ce)
      st_reg <= st_next;
  end

  assign rdata = st_reg.rdata;
  assign tone_pin = st_reg.pin;

  sequence s_trig_w;
    ce && trig_acc && !kill_acc;
  endsequence

  sequence s_kill_w;
    ce && kill_acc;
  endsequence

  sequence s_ctl_rd;
    ce && bus.rd && hit(bus, CTL_ADDR);
  endsequence

  a_kill_stops: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_kill_w |=> st_reg.bst == BST_IDLE)
    else $error("kill did not stop burst");

  a_trig_env_clear: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce && trig_acc |=> !st_reg.env_en)
    else $error("trigger left envelope enabled");

  a_trig_ignored: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce && wr_ctl && st_reg.ton && bus.wdata[B_TRIG] && st_reg.bst == BST_IDLE
    |=> st_reg.bst == BST_IDLE)
    else $error("trigger taken while tone on");

  a_start_on_tick: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(st_reg.bst == BST_RUN) |-> $past(slow_tick) && $past(ce))
    else $error("burst started off tick");

  a_end_on_tick: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $past(st_reg.bst) == BST_RUN && st_reg.bst == BST_IDLE
    |-> $past(slow_tick) || $past(kill_acc))
    else $error("burst ended off tick");

  a_retrig_extend: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_trig_w and (st_reg.bst == BST_RUN) |=> st_reg.bst == BST_RUN && st_reg.burst_cnt == 6'h00)
    else $error("retrigger did not restart timer");

  a_restart_lvl1: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce && rst_acc && st_reg.ton && !(wr_ctl && !bus.wdata[B_TON]) |=> st_reg.env_lvl == 3'h0)
    else $error("restart did not return to level 1");

  a_env_hold8: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    st_reg.env_lvl == LEVEL_MIN && st_reg.ton && st_reg.env_en && !wr_ctl
    |=> st_reg.env_lvl == LEVEL_MIN)
    else $error("level 8 not held");

  a_busy_read: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    s_ctl_rd |=> rdata[B_TRIG] == ($past(st_reg.bst) != BST_IDLE)
    && rdata[B_KILL] == 1'b0 && rdata[B_RST] == 1'b0)
    else $error("status read wrong");

  a_pin_low_off: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce && !st_reg.ton && st_reg.bst != BST_RUN |=> !tone_pin)
    else $error("pin not low while off");
endmodule
`default_nettype wire

/* logic/bzg_tone.sv */
// tone waveform from pitch and duty level, advanced by the base tick
// assumes tick is a one-cycle pulse at the base rate
`timescale 1ns/1ns
`default_nettype none
module bzg_tone (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic [2:0] pitch,
  input  wire logic [2:0] level,
  output logic            wave
);
  import bzg_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic       wave;
  } bzg_tn_st_t;

  bzg_tn_st_t st_reg;
  bzg_tn_st_t st_next;
  logic [5:0] period;
  logic [5:0] high;

  // period 16..28 base ticks, doubled for the lower octave
  always_comb
  begin
    period = 6'(16 + 4 * pitch[1:0]) << pitch[2];
    high = 6'((pitch[1] ? 12 : 8) - level) << pitch[2];
  end

  always_comb
  begin
    st_next = st_reg;
    if (tick)
    begin
      st_next.cnt = (st_reg.cnt >= period - 6'h01) ? 6'h00 : st_reg.cnt + 6'h01;
      st_next.wave = st_next.cnt < high;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign wave = st_reg.wave;
endmodule
`default_nettype wire

/* tb/bzg_buzzer_tb_top.sv */
// register-level testbench of the buzzer tone generator
// assumes a fast base rate so one slow tick is 512 clocks
`timescale 1ns/1ns
`default_nettype none
module bzg_buzzer_tb_top;
  import bzg_pkg::*;
  localparam int BHZ = 50_000_000;
  // base tick every 2 clocks, slow tick every 256 of them
  localparam int SLOW = 512;
  localparam int STAGE = 16 * SLOW;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  bzg_bus_t   bus = '0;
  logic [7:0] rdata;
  logic       tone_pin;
  logic [7:0] d;
  int         per, high, rises, n, t0;
  int         errors = 0;
  int         comparisons = 0;
  int         cyc_n = 0;

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc_n <= cyc_n + 1;

  bzg_buzzer #(.BASE_HZ(BHZ)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .bus(bus), .rdata(rdata),
    .tone_pin(tone_pin));
  bzg_piezo i_piezo (.ref_clk(ref_clk), .tone_pin(tone_pin), .per(per), .high(high), .rises(rises));

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic fail(input string nm);
    errors++;
    $display("Error %s expected done seen timeout", nm);
    conclude();
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi)
    begin
      errors++;
      $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic wait_n(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk8(nm, e, d);
  endtask

  // let a few tone periods pass before trusting the measurement
  task automatic duty(input string nm, input int h);
    wait_n(100);
    chk_rng(nm, h, h, high);
  endtask

  task automatic steady(input string nm);
    n = rises;
    wait_n(100);
    chk_rng(nm, n, n, rises);
  endtask

  task automatic wait_rise(input int lim);
    n = rises;
    for (int k = 0; k < lim && rises == n; k++) wait_n(1);
    if (rises == n) fail("pin rise");
  endtask

  task automatic wait_busy(input int lim);
    rd(CTL_ADDR);
    for (int k = 0; k < lim && d[5] !== 1'b0; k++) rd(CTL_ADDR);
    if (d[5] !== 1'b0) fail("busy");
  endtask

  initial
  begin
    wait_n(5);
    rstn <= 1'b1;
    chk8("pin", 8'h00, {7'h0, tone_pin});
    rdchk("ctl", CTL_ADDR, 8'h00);
    rdchk("sel", SEL_ADDR, 8'h00);
    rdchk("unmapped", 16'hff46, 8'h00);
    wr(SEL_ADDR, 8'h30);
    rdchk("sel", SEL_ADDR, 8'h30);
    wr(CTL_ADDR, 8'h01);
    duty("fixed level", 10);
    chk_rng("period", 32, 32, per);
    wr(SEL_ADDR, 8'h07);
    wait_n(300);
    chk_rng("low pitch period", 112, 112, per);
    chk_rng("low pitch high", 48, 48, high);
    wr(SEL_ADDR, 8'h30);
    wait_n(300);
    wr(CTL_ADDR, 8'h03);
    rdchk("ctl", CTL_ADDR, 8'h03);
    duty("env level 1", 16);
    wait_n(3 * STAGE / 2);
    duty("env level 2", 14);
    wr(CTL_ADDR, 8'h07);
    rdchk("restart bit", CTL_ADDR, 8'h03);
    duty("restart", 16);
    // seven stage ends plus one slow-tick phase, with margin
    wait_n(15 * STAGE / 2);
    duty("env floor", 2);
    wr(CTL_ADDR, 8'h00);
    wr(CTL_ADDR, 8'h03);
    duty("tone re-on", 16);
    wr(CTL_ADDR, 8'h00);
    steady("pin off");
    t0 = cyc_n;
    wr(CTL_ADDR, 8'h22);
    rdchk("trigger", CTL_ADDR, 8'h20);
    // armed up to one slow tick, then up to one tone period to the first rise
    wait_rise(SLOW + 64);
    duty("burst level", 10);
    wait_busy(3000);
    chk_rng("burst length", 8 * SLOW, 9 * SLOW + 8, cyc_n - t0);
    steady("after burst");
    wr(CTL_ADDR, 8'h20);
    wait_n(1000);
    wr(CTL_ADDR, 8'h40);
    rdchk("kill", CTL_ADDR, 8'h00);
    steady("killed");
    wr(CTL_ADDR, 8'h60);
    rdchk("trigger and kill", CTL_ADDR, 8'h00);
    wr(CTL_ADDR, 8'h20);
    wait_n(2000);
    wr(CTL_ADDR, 8'h20);
    wait_n(3000);
    rdchk("retrigger", CTL_ADDR, 8'h20);
    wr(CTL_ADDR, 8'h40);
    wr(CTL_ADDR, 8'h30);
    wait_n(5000);
    rdchk("long burst", CTL_ADDR, 8'h30);
    wr(CTL_ADDR, 8'h40);
    wr(CTL_ADDR, 8'h0b);
    wr(CTL_ADDR, 8'h2b);
    rdchk("trigger ignored", CTL_ADDR, 8'h0b);
    wr(CTL_ADDR, 8'h4b);
    rdchk("kill ignored", CTL_ADDR, 8'h0b);
    // clock enable low must freeze every register, writes included
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(CTL_ADDR, 8'h00);
    @(posedge ref_clk);
    ce <= 1'b1;
    rdchk("frozen by ce", CTL_ADDR, 8'h0b);
    conclude();
  end
endmodule
`default_nettype wire

/* tb/bzg_piezo.sv */
// piezo buzzer model: measures period and high time of the tone pin
// assumes the pin is sampled on the system clock rising edge
`timescale 1ns/1ns
`default_nettype none
module bzg_piezo (
  input  wire logic ref_clk,
  input  wire logic tone_pin,
  output int        per,
  output int        high,
  output int        rises
);
  logic prev = 1'b0;
  int   since = 0;
  int   run = 0;

  initial
  begin
    per = 0;
    high = 0;
    rises = 0;
  end

  // latch held at zero, pin seen as driven
  always @(posedge ref_clk)
  begin
    prev <= tone_pin;
    if (tone_pin && !prev)
    begin
      per <= since;
      high <= run;
      rises <= rises + 1;
      since <= 1;
      run <= 1;
    end
    else
    begin
      since <= since + 1;
      run <= run + int'(tone_pin);
    end
  end
endmodule
`default_nettype wire
